// [logic/power_stage_regs.svh]
// offsets, field positions, reset values and timing counts of the power stage control
// Operation
// R1: outputs follow their own input, normally uninverted
// R2: some modes invert inputs to drive bridge sides
// R3: controller grounds inputs of unused outputs
// R4: controller keeps mode select static while running
// R5: mixed mode ramps only outputs one and two
// R6: over-current, thermal error, under-voltage force shutdown
// R7: flags are active-low open-drain pull-downs
// R8: over-current flagged per pair, two flags
// R9: over-current trip holds until reset toggled
// R10: pair flag low when either channel over-current
// R11: thermal warning pulls its flag, no shutdown
// R12: thermal error pulls combined error flag low
// R13: supply under-voltage pulls combined error flag
// R14: thermal or supply error trips all four
// R15: pair reset low clears state, outputs released
// R16: output waits for own rising input edge
// R17: codes 001 and 101 select mixed mode
// R18: sensed levels synchronised, trips persist until released
`ifndef POWER_STAGE_REGS_SVH
`define POWER_STAGE_REGS_SVH

// register byte offsets
`define CTRL_OFFSET      4'h0
`define STATUS_OFFSET    4'h4

// control register fields
`define CTRL_MODE_LSB    0
`define CTRL_RAMP_BIT    3
`define CTRL_RESET       4'h0

// status register fields
`define STAT_DRIVE_LSB   0
`define STAT_TRIP_LSB    4
`define STAT_WARN_BIT    7
`define STAT_RAMP_LSB    8
`define STAT_PIN_LSB     10

// mixed mode codes
`define MODE_MIXED_A     3'h1
`define MODE_MIXED_B     3'h5

// bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// soft ramp timing: nominal ramp time and clock period
`define RAMP_TIME_US     100
`define CLK_PERIOD_NS    8
`define RAMP_CYCLES_DEF  ((`RAMP_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [logic/power_stage_pkg.sv]
// shared types of the power stage control
package power_stage_pkg;

  // per-output lane sequencing
  typedef enum logic [1:0] {
    LANE_OFF   = 2'b00,
    LANE_WAIT  = 2'b01,
    LANE_DRIVE = 2'b10
  } lane_state_t;

  // levels from the analog comparators
  typedef struct packed {
    logic [3:0] overcurrent;
    logic       thermal_warning;
    logic       thermal_error;
    logic       high_voltage_supply_low;
  } sense_t;

  // which input feeds a lane and whether it is inverted
  typedef struct packed {
    logic [1:0] src;
    logic       inv;
  } route_t;

endpackage : power_stage_pkg

// [logic/output_lane.sv]
// one switched power output: arming on input edge, drive and release
`timescale 1ns/1ps
module output_lane
  import power_stage_pkg::*;
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  run,
  input  wire logic  source_in,
  input  wire logic  drive_val,
  input  wire logic  ramp_busy,
  output logic       out_q,
  output logic       oe_q,
  output lane_state_t state_q
);

  lane_state_t state_d;
  logic        prev_q;
  logic        seen_q;
  logic        seen_d;
  logic        out_d;
  logic        oe_d;

  // next state; losing run always drops back to released
  always_comb begin
    state_d = state_q;
    seen_d  = seen_q;
    out_d   = 1'b0;
    oe_d    = 1'b0;
    unique case (state_q)
      LANE_OFF: begin
        seen_d = 1'b0;
        if (run) begin
          state_d = LANE_WAIT;
        end
      end
      LANE_WAIT: begin
        // only a low-to-high edge arms; a static level never does
        if (source_in && !prev_q) begin
          seen_d = 1'b1;  // [R16]
        end
        // an early edge is remembered while the ramp finishes
        if (seen_d && !ramp_busy) begin
          state_d = LANE_DRIVE;  // [R16]
        end
      end
      LANE_DRIVE: begin
        out_d = drive_val;
        oe_d  = 1'b1;
      end
      default: state_d = LANE_OFF;
    endcase
    if (!run) begin
      state_d = LANE_OFF;  // [R15]
      out_d   = 1'b0;
      oe_d    = 1'b0;
    end
  end

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= LANE_OFF;
      prev_q  <= 1'b0;
      seen_q  <= 1'b0;
      out_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      prev_q  <= source_in;
      seen_q  <= seen_d;
      out_q   <= out_d;
      oe_q    <= oe_d;
    end
  end

endmodule : output_lane

// [logic/power_stage_output_protection.sv]
// four-output power stage control: routing, protection, flags and register slave
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "power_stage_regs.svh"
module power_stage_output_protection
  import power_stage_pkg::*;
#(
  parameter int unsigned ADDR_W      = 4,
  parameter int unsigned RAMP_CYCLES = `RAMP_CYCLES_DEF
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // register bus
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // modulator, reset controller and comparator side
  input  wire logic [3:0]        pwm_input_n,
  input  wire logic              reset_pair_a_n,
  input  wire logic              reset_pair_b_n,
  input  wire sense_t            analog_sense,
  // switched outputs
  output logic [3:0]             power_output_n,
  output logic [3:0]             power_output_n_oe,
  // open-drain flags
  input  wire logic              overcurrent_flag_pair_a_n_i,
  output logic                   overcurrent_flag_pair_a_n,
  output logic                   overcurrent_flag_pair_a_n_oe,
  input  wire logic              overcurrent_flag_pair_b_n_i,
  output logic                   overcurrent_flag_pair_b_n,
  output logic                   overcurrent_flag_pair_b_n_oe,
  input  wire logic              thermal_warning_flag_n_i,
  output logic                   thermal_warning_flag_n,
  output logic                   thermal_warning_flag_n_oe,
  input  wire logic              thermal_undervoltage_error_n_i,
  output logic                   thermal_undervoltage_error_n,
  output logic                   thermal_undervoltage_error_n_oe
);

  localparam int unsigned RW = $clog2(RAMP_CYCLES + 1);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************

  // decode needs at least the two registers; counter must stay sane
  if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end
  if (RAMP_CYCLES < 1 || RAMP_CYCLES > 24'hFFFFFF) begin : g_bad_ramp
    $error("RAMP_CYCLES out of range");
  end

  // ****************************************************************
  // comparator synchroniser
  // ****************************************************************

  sense_t sense_s1_q;
  sense_t sense_s1_d;
  sense_t sense_s2_q;
  sense_t sense_s2_d;

  // two stages; the comparators are asynchronous to aclk
  always_comb begin
    sense_s1_d = analog_sense;  // [R18]
    sense_s2_d = sense_s1_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_s1_q <= '0;
      sense_s2_q <= '0;
    end else begin
      sense_s1_q <= sense_s1_d;
      sense_s2_q <= sense_s2_d;
    end
  end

  // ****************************************************************
  // fault latches
  // ****************************************************************

  logic [1:0] pair_n;
  logic [1:0] oc_now;
  logic       uvte_now;
  logic [1:0] oc_q;
  logic [1:0] oc_d;
  logic       uvte_q;
  logic       uvte_d;
  logic [1:0] seen_low_q;
  logic [1:0] seen_low_d;

  assign pair_n   = {reset_pair_b_n, reset_pair_a_n};
  assign oc_now   = {|sense_s2_q.overcurrent[3:2], |sense_s2_q.overcurrent[1:0]};  // [R8]
  assign uvte_now = sense_s2_q.thermal_error | sense_s2_q.high_voltage_supply_low;

  // an over-current trip clears only while its pair reset is low and the cause is gone;
  // a fresh fault always wins over the release
  always_comb begin
    oc_d = oc_now | (oc_q & pair_n);  // [R9]
    // remember each pair reset seen low with the cause gone
    for (int p = 0; p < 2; p++) begin
      seen_low_d[p] = uvte_q && !uvte_now && (seen_low_q[p] || !pair_n[p]);
    end
    // both pairs must have gone low and come back high
    uvte_d = uvte_now || (uvte_q && !((&seen_low_q) && (&pair_n)));  // [R14]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_q       <= 2'h0;
      uvte_q     <= 1'b0;
      seen_low_q <= 2'h0;
    end else begin
      oc_q       <= oc_d;  // [R18]
      uvte_q     <= uvte_d;
      seen_low_q <= seen_low_d;
    end
  end

  // ****************************************************************
  // flag drivers
  // ****************************************************************

  logic [3:0] flag_oe_q;
  logic [3:0] flag_oe_d;

  // warning only signals; it never feeds the lane run terms
  always_comb begin
    flag_oe_d[0] = oc_q[0] | oc_now[0];  // [R10]
    flag_oe_d[1] = oc_q[1] | oc_now[1];  // [R10]
    flag_oe_d[2] = sense_s2_q.thermal_warning;  // [R11]
    flag_oe_d[3] = uvte_q | uvte_now;  // [R12] [R13]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_oe_q <= 4'h0;
    end else begin
      flag_oe_q <= flag_oe_d;
    end
  end

  // open drain: only ever pull low, otherwise release to the pull-up
  assign overcurrent_flag_pair_a_n       = 1'b0;  // [R7]
  assign overcurrent_flag_pair_b_n       = 1'b0;
  assign thermal_warning_flag_n          = 1'b0;
  assign thermal_undervoltage_error_n    = 1'b0;
  assign overcurrent_flag_pair_a_n_oe    = flag_oe_q[0];
  assign overcurrent_flag_pair_b_n_oe    = flag_oe_q[1];
  assign thermal_warning_flag_n_oe       = flag_oe_q[2];
  assign thermal_undervoltage_error_n_oe = flag_oe_q[3];

  // ****************************************************************
  // control register and soft ramp
  // ****************************************************************

  logic [3:0]    ctrl_q;
  logic [3:0]    ctrl_d;
  logic [2:0]    output_mode_select;
  logic          ramp_enable;
  logic          mixed_mode;
  logic [1:0]    ramp_apply;
  logic [1:0]    ramp_busy;
  logic [RW-1:0] ramp_cnt_q [2];
  logic [RW-1:0] ramp_cnt_d [2];

  assign output_mode_select = ctrl_q[`CTRL_MODE_LSB +: 3];
  assign ramp_enable        = ctrl_q[`CTRL_RAMP_BIT];
  assign mixed_mode         = (output_mode_select == `MODE_MIXED_A) ||
                              (output_mode_select == `MODE_MIXED_B);  // [R17]
  // the bridged pair never ramps in mixed mode
  assign ramp_apply         = {ramp_enable & ~mixed_mode, ramp_enable};  // [R5]

  // counter reloads in reset and runs down after release
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      if (!pair_n[p]) begin
        ramp_cnt_d[p] = RW'(RAMP_CYCLES);
      end else if (ramp_cnt_q[p] != '0) begin
        ramp_cnt_d[p] = ramp_cnt_q[p] - 1'b1;
      end else begin
        ramp_cnt_d[p] = ramp_cnt_q[p];
      end
      ramp_busy[p] = ramp_apply[p] && (ramp_cnt_q[p] != '0);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_cnt_q[0] <= '0;
      ramp_cnt_q[1] <= '0;
    end else begin
      ramp_cnt_q[0] <= ramp_cnt_d[0];
      ramp_cnt_q[1] <= ramp_cnt_d[1];
    end
  end

  // ****************************************************************
  // routing and output lanes
  // ****************************************************************

  // routing ignores mode[2]; the two mixed codes route alike
  function automatic route_t lane_route(input logic [2:0] mode, input logic [1:0] lane);
    route_t r;
    r.src = lane;
    r.inv = 1'b0;
    unique case (mode[1:0])
      2'b00: r.inv = 1'b0;
      2'b01: if (lane == 2'd3) begin
        r.src = 2'd2;
        r.inv = 1'b1;
      end
      2'b10: if (lane[0]) begin
        r.src = {lane[1], 1'b0};
        r.inv = 1'b1;
      end
      2'b11: begin
        r.src = 2'd0;
        r.inv = lane[1];
      end
    endcase
    return r;
  endfunction : lane_route

  logic [3:0]  lane_run;
  logic [3:0]  lane_src;
  logic [3:0]  lane_val;
  lane_state_t lane_state [4];

  // any live fault drops the lane run term in the same cycle it is seen; the output releases at the next edge
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      route_t rt;
      rt = lane_route(output_mode_select, 2'(k));
      lane_src[k] = pwm_input_n[rt.src];
      lane_val[k] = pwm_input_n[rt.src] ^ rt.inv;  // [R1] [R2]
      lane_run[k] = pair_n[k / 2] && !oc_q[k / 2] && !oc_now[k / 2] &&
                    !uvte_q && !uvte_now;  // [R6] [R9] [R14] [R15]
    end
  end

  for (genvar k = 0; k < 4; k++) begin : g_lane
    output_lane u_lane (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .run       (lane_run[k]),
      .source_in (lane_src[k]),
      .drive_val (lane_val[k]),
      .ramp_busy (ramp_busy[k / 2]),
      .out_q     (power_output_n[k]),
      .oe_q      (power_output_n_oe[k]),
      .state_q   (lane_state[k])
    );
  end

  // ****************************************************************
  // register slave
  // ****************************************************************

  logic              aw_q;
  logic              aw_d;
  logic [ADDR_W-1:0] awaddr_q;
  logic [ADDR_W-1:0] awaddr_d;
  logic              w_q;
  logic              w_d;
  logic [31:0]       wdata_q;
  logic [31:0]       wdata_d;
  logic [3:0]        wstrb_q;
  logic [3:0]        wstrb_d;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;
  logic [1:0]        bresp_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic [1:0]        rresp_q;
  logic [1:0]        rresp_d;
  logic [31:0]       status;

  // status is a live view, sampled when the read is taken
  always_comb begin
    status = 32'h0;
    status[`STAT_DRIVE_LSB +: 4] = power_output_n_oe;
    status[`STAT_TRIP_LSB +: 3]  = {uvte_q, oc_q};
    status[`STAT_WARN_BIT]       = sense_s2_q.thermal_warning;
    status[`STAT_RAMP_LSB +: 2]  = ramp_busy;
    status[`STAT_PIN_LSB +: 4]   = {thermal_undervoltage_error_n_i, thermal_warning_flag_n_i,
                                    overcurrent_flag_pair_b_n_i, overcurrent_flag_pair_a_n_i};
  end

  // one write and one read in flight; a new request waits for the answer
  assign awready = !aw_q && !bvalid_q;
  assign wready  = !w_q && !bvalid_q;
  assign arready = !rvalid_q;

  // write and read next values; only the control word is writable
  always_comb begin
    aw_d     = aw_q;
    awaddr_d = awaddr_q;
    w_d      = w_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    ctrl_d   = ctrl_q;
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (awvalid && awready) begin
      aw_d     = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_d     = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_q && w_q && !bvalid_q) begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = `RESP_SLVERR;
      if ({awaddr_q[ADDR_W-1:2], 2'b00} == ADDR_W'(`CTRL_OFFSET)) begin
        bresp_d = `RESP_OKAY;
        if (wstrb_q[0]) begin
          ctrl_d = wdata_q[3:0];
        end
      end
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h0;
      rresp_d  = `RESP_OKAY;
      if ({araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(`CTRL_OFFSET)) begin
        rdata_d = {28'h0, ctrl_q};
      end else if ({araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(`STATUS_OFFSET)) begin
        rdata_d = status;
      end else begin
        rresp_d = `RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      awaddr_q <= '0;
      w_q      <= 1'b0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
      ctrl_q   <= `CTRL_RESET;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= `RESP_OKAY;
    end else begin
      aw_q     <= aw_d;
      awaddr_q <= awaddr_d;
      w_q      <= w_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      ctrl_q   <= ctrl_d;
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  // ****************************************************************
  // assertions
  // ****************************************************************

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_follow_input: assert property (  // [R1]
    power_output_n_oe[0] |-> power_output_n[0] == $past(pwm_input_n[0]))
    else $error("output one does not follow its input");

  a_bridge_invert: assert property (  // [R2] [R17]
    power_output_n_oe[3] && $past(mixed_mode) |-> power_output_n[3] == !$past(pwm_input_n[2]))
    else $error("bridged side not inverted in mixed mode");

  a_mixed_no_ramp: assert property (  // [R5]
    mixed_mode |-> !ramp_busy[1])
    else $error("bridged pair ramps in mixed mode");

  a_oc_release: assert property (  // [R9]
    oc_now[0] |=> !power_output_n_oe[0] && !power_output_n_oe[1] && oc_q[0])
    else $error("pair a still driven after over-current");

  a_oc_flag: assert property (  // [R8] [R10]
    oc_now[1] |=> overcurrent_flag_pair_b_n_oe ##1 overcurrent_flag_pair_b_n_oe)
    else $error("pair b over-current flag not pulled low");

  a_uvte_all_off: assert property (  // [R14] [R6]
    uvte_now |=> power_output_n_oe == 4'h0 && thermal_undervoltage_error_n_oe)
    else $error("outputs driven during thermal or supply error");

  a_warn_no_trip: assert property (  // [R11]
    power_output_n_oe[0] && sense_s2_q.thermal_warning && lane_run[0]
      |=> power_output_n_oe[0] && thermal_warning_flag_n_oe)
    else $error("warning stopped an output or left flag high");

  a_reset_release: assert property (  // [R15]
    !reset_pair_b_n [*2] |-> !power_output_n_oe[2] && !power_output_n_oe[3])
    else $error("pair b driven while held in reset");

  a_trip_holds: assert property (  // [R18]
    uvte_q && reset_pair_a_n && reset_pair_b_n && !(&seen_low_q) |=> uvte_q)
    else $error("thermal or supply trip released without reset toggle");

  a_edge_needed: assert property (  // [R16]
    $rose(power_output_n_oe[0]) |-> lane_state[0] == LANE_DRIVE && $past(lane_run[0], 2))
    else $error("output one enabled without arming");

  c_drive_all: cover property (power_output_n_oe == 4'hF);
  c_oc_trip: cover property ($rose(oc_q[0]));
  c_uvte_release: cover property ($fell(uvte_q));

endmodule : power_stage_output_protection

// [verification/pwm_partner.sv]
// modulator and reset controller model feeding the power stage control
`timescale 1ns/1ps
module pwm_partner (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] level,
  input  wire logic [1:0] pair_on,
  output logic      [3:0] pwm_input_n,
  output logic            reset_pair_a_n,
  output logic            reset_pair_b_n
);
  // ************************************************************
  // registered drive
  // ************************************************************
  // all outputs launch just after the edge, as a real modulator stage does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_input_n    <= 4'h0; // inputs of unused outputs stay grounded
      reset_pair_a_n <= 1'b0; // pairs held in reset until asked
      reset_pair_b_n <= 1'b0;
    end else begin
      pwm_input_n    <= level;
      reset_pair_a_n <= pair_on[0]; // low then high releases a trip
      reset_pair_b_n <= pair_on[1];
    end
  end
endmodule : pwm_partner

// [verification/testbench.sv]
// self-checking bench for the power stage control
`timescale 1ns/1ps
module testbench;
  import power_stage_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, reset_pair_a_n, reset_pair_b_n;
  logic [3:0]  awaddr, araddr, wstrb, pwm_input_n, power_output_n, power_output_n_oe, level;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, pair_on;
  logic [2:0]  m;
  sense_t      analog_sense;
  logic overcurrent_flag_pair_a_n, overcurrent_flag_pair_a_n_oe, overcurrent_flag_pair_a_n_i;
  logic overcurrent_flag_pair_b_n, overcurrent_flag_pair_b_n_oe, overcurrent_flag_pair_b_n_i;
  logic thermal_warning_flag_n, thermal_warning_flag_n_oe, thermal_warning_flag_n_i;
  logic thermal_undervoltage_error_n, thermal_undervoltage_error_n_oe;
  logic thermal_undervoltage_error_n_i;
  int   err_total, num_checks, cycles;
  // ************************************************************
  // clock, pull-ups, instances
  // ************************************************************
  always #4 aclk = ~aclk;
  // released open-drain pins float up through the board pull-up
  assign overcurrent_flag_pair_a_n_i = overcurrent_flag_pair_a_n_oe ? 1'b0 : 1'b1;
  assign overcurrent_flag_pair_b_n_i = overcurrent_flag_pair_b_n_oe ? 1'b0 : 1'b1;
  assign thermal_warning_flag_n_i = thermal_warning_flag_n_oe ? 1'b0 : 1'b1;
  assign thermal_undervoltage_error_n_i = thermal_undervoltage_error_n_oe ? 1'b0 : 1'b1;
  // short ramp keeps the run brief
  power_stage_output_protection #(.RAMP_CYCLES(40)) power_stage_output_protection_inst (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .pwm_input_n, .reset_pair_a_n, .reset_pair_b_n, .analog_sense,
    .power_output_n, .power_output_n_oe, .overcurrent_flag_pair_a_n,
    .overcurrent_flag_pair_a_n_oe, .overcurrent_flag_pair_a_n_i, .overcurrent_flag_pair_b_n,
    .overcurrent_flag_pair_b_n_oe, .overcurrent_flag_pair_b_n_i, .thermal_warning_flag_n,
    .thermal_warning_flag_n_oe, .thermal_warning_flag_n_i, .thermal_undervoltage_error_n,
    .thermal_undervoltage_error_n_oe, .thermal_undervoltage_error_n_i);
  pwm_partner pwm_partner_inst (.aclk, .aresetn, .level, .pair_on, .pwm_input_n,
    .reset_pair_a_n, .reset_pair_b_n);
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // handshakes are judged on the level held just before the edge, so no race
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      aw = awready;
      w  = wready;
      b  = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
    tick(1);
    check(r, er);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, input logic [1:0] er);
    logic ar, v;
    logic [1:0] r;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ar = arready;
      v  = rvalid;
      r  = rresp;
      rd = rdata;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end while (!v);
    rready <= 1'b0;
    tick(1);
    check(r, er);
  endtask : axi_read
  // rising edge on every used input arms its lanes
  task automatic arm(input logic [3:0] mask);
    level <= 4'h0;
    tick(3);
    level <= mask;
    tick(6);
  endtask : arm
  task automatic cycle_pairs(input logic [1:0] low);
    pair_on <= ~low;
    tick(3);
    pair_on <= 2'h3;
    tick(3);
    arm(4'hF);
  endtask : cycle_pairs
  function automatic logic [3:0] route_exp(input logic [2:0] md, input logic [3:0] i);
    case (md[1:0])
      2'h0:    return i;
      2'h1:    return {~i[2], i[2:0]};
      2'h2:    return {~i[2], i[2], ~i[0], i[0]};
      default: return {~i[0], ~i[0], i[0], i[0]};
    endcase
  endfunction : route_exp
  // ************************************************************
  // watchdog and main sequence
  // ************************************************************
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    {aclk, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, level, pair_on, analog_sense} = '0;
    wstrb = 4'hF;
    {err_total, num_checks, cycles} = '0;
    aresetn = 1'b0;
    tick(10);
    aresetn <= 1'b1;
    axi_read(4'h0, 2'h0);
    check(rd, 32'h0);
    axi_read(4'h4, 2'h0);
    check(rd, 32'h00003C00); // all flag pins released high
    axi_read(4'hC, 2'h2);
    check(rd, 32'h0);
    axi_write(4'h4, 32'h0000000F, 2'h2);
    axi_write(4'h8, 32'h0000000F, 2'h2);
    axi_write(4'h0, 32'h0000000D, 2'h0);
    axi_read(4'h0, 2'h0);
    check(rd, 32'h0000000D);
    // modes 0 to 3 and 5, mode changed only with both pairs held in reset
    for (int k = 0; k < 5; k++) begin
      m = (k == 4) ? 3'h5 : 3'(k);
      pair_on <= 2'h0;
      level   <= 4'h0;
      tick(3);
      axi_write(4'h0, {29'h0, m}, 2'h0);
      pair_on <= 2'h3;
      tick(6);
      check(power_output_n_oe, 4'h0); // no drive before a rising input
      arm(m[1:0] == 2'h3 ? 4'h1 : (m[1:0] == 2'h2 ? 4'h5 : (m[0] ? 4'h7 : 4'hF)));
      check(power_output_n_oe, 4'hF);
      check(power_output_n, route_exp(m, level));
      level <= 4'h0;
      tick(4);
      check(power_output_n, route_exp(m, 4'h0));
    end
    // mixed mode never ramps the bridged pair
    for (int k = 0; k < 2; k++) begin
      pair_on <= 2'h0;
      tick(3);
      axi_write(4'h0, {28'h0, 1'b1, (k ? 3'h5 : 3'h0)}, 2'h0);
      pair_on <= 2'h3;
      tick(2);
      axi_read(4'h4, 2'h0);
      check(rd[9:8], k ? 2'h1 : 2'h3);
      tick(50);
    end
    pair_on <= 2'h0;
    tick(3);
    axi_write(4'h0, 32'h0, 2'h0);
    cycle_pairs(2'h3);
    // over-current on one channel of each pair
    for (int c = 1; c < 3; c++) begin
      analog_sense.overcurrent[c] <= 1'b1;
      tick(6);
      check(power_output_n_oe, c < 2 ? 4'hC : 4'h3);
      check({overcurrent_flag_pair_b_n_oe, overcurrent_flag_pair_a_n_oe}, c);
      analog_sense <= '0;
      tick(6);
      check(power_output_n_oe, c < 2 ? 4'hC : 4'h3); // trip holds after cause goes
      cycle_pairs(2'h3);
      check(power_output_n_oe, 4'hF);
    end
    analog_sense.thermal_warning <= 1'b1;
    tick(6);
    check(thermal_warning_flag_n_oe, 1'b1);
    check(power_output_n_oe, 4'hF); // warning alone keeps drive
    analog_sense <= '0;
    tick(2);
    // thermal error then supply under-voltage
    for (int j = 0; j < 2; j++) begin
      if (j == 0) analog_sense.thermal_error <= 1'b1;
      else analog_sense.high_voltage_supply_low <= 1'b1;
      tick(6);
      check(thermal_undervoltage_error_n_oe, 1'b1);
      check(power_output_n_oe, 4'h0);
      analog_sense <= '0;
      tick(4);
      cycle_pairs(2'h1);
      check(power_output_n_oe, 4'h0); // one pair toggled is not enough
      cycle_pairs(2'h3);
      check(power_output_n_oe, 4'hF);
    end
    wrap_up();
  end
endmodule : testbench
